// file: clk_switch_pkg.sv
// Purpose: Shared constants and types for the system clock switch control.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word each.
// Notes: Oscillator index doubles as the source select code.
package clk_switch_pkg;

  // Register byte offsets
  localparam logic [7:0] CLOCK_REQUEST_OFS = 8'h00;
  localparam logic [7:0] CLOCK_CURRENT_OFS = 8'h04;
  localparam logic [7:0] SWITCH_STATUS_OFS = 8'h08;
  localparam logic [7:0] OSC_STATUS_OFS = 8'h0C;
  localparam logic [7:0] OSC_ENABLE_OFS = 8'h10;
  localparam logic [7:0] FREQ_SELECT_OFS = 8'h14;
  localparam logic [7:0] SWITCH_IRQ_OFS = 8'h18;

  // Field positions
  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int HOLD_BIT = 7;
  localparam int READY_BIT = 4;
  localparam int NEW_READY_BIT = 3;
  localparam int FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  // Oscillators; source code n selects oscillator n
  localparam int NUM_OSC = 7;
  localparam int MID_FREQ_IDX = 3;
  localparam int HIGH_FREQ_IDX = 4;
  localparam int PLL_IDX = 6;
  localparam logic [NUM_OSC-1:0] MANUAL_EN_MASK = 7'h3F;

  // Reset values
  localparam logic [2:0] RST_SRC = 3'h4;
  localparam logic [3:0] RST_DIV = 4'h0;
  localparam logic [3:0] RST_FREQ = 4'h2;

  // Settle time of the internal oscillator after a frequency change
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_READY = 3'b100
  } switch_state_e;

  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } clock_sel_s;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

endpackage

// file: osc_settle_timer.sv
// Purpose: Tracks settling of the internal oscillator after a frequency change.
// Assumes: restart_i is a one-cycle pulse on each frequency select write.
// Notes: Settled output comes from a flop; a restart always wins.
`timescale 1ns/10ps
`default_nettype none
module osc_settle_timer
  import clk_switch_pkg::*;
(
  input wire logic clock_i,  // System clock
  input wire logic nrst_i,   // Synchronous reset, active low
  input wire logic restart_i, // Frequency select written
  output logic settled_o     // Oscillator output accurate
);

  logic [SETTLE_W-1:0] count;

  // Count down from the settle time; retrigger restarts the wait
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      count <= '0;
      settled_o <= 1'b1;
    end else if (restart_i) begin
      count <= SETTLE_W'(SETTLE_CYCLES);
      settled_o <= 1'b0;
    end else if (count != '0) begin
      count <= count - 1'b1;
      settled_o <= (count == SETTLE_W'(1));
    end
  end

endmodule
`default_nettype wire

// file: clk_switch_ctrl.sv
// Purpose: System clock source and divider switch control with registers.
// Assumes: Oscillator ready inputs are synchronous to clock_i.
// Notes: Outputs select the clock; the glitch-free mux sits downstream.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Status register shows ready of every oscillator, converter RC included.
// - Manual enable register forces oscillators on; PLL cannot be forced.
// - High and mid internal clocks always usable; ready bits mean accurate. Here a switch to either still waits for its ready bit.
// - Writing frequency select clears both internal ready bits until settled.
// - Mid internal clock held static while frequency change is pending.
// - Requested source and divider choose the clock for CPU and peripherals.
// - Old selection keeps clocking until requested source is ready.
// - Source already running, or divider-only change, counts as ready at once.
// - New-source-ready and switch flag set together when source is ready.
// - Switch interrupt request only while the interrupt enable is one.
// - Switch flag is never a wake source.
// - Pollable switch-ready bit shows readiness without the interrupt.
// - Hold clear: changeover follows as soon as new-source-ready sets.
// - Hold set: changeover suspended, old clock continues.
// - During hold, clear hold to finish or copy current into request.
// - Under reduced CPU rate the switch still happens the next cycle.
// - Divider-only change uses the same sequence and needs hold clear.
// - Current status shows old selection until changeover, then switch-ready.
// - New-source-ready clears in hardware once the switch completes.
module clk_switch_ctrl
  import clk_switch_pkg::*;
(
  input wire logic clock_i,                 // System clock
  input wire logic nrst_i,                  // Synchronous reset, active low
  input wire axil_req_s axil_req_i,         // AXI4-Lite master signals
  output axil_rsp_s axil_rsp_o,             // AXI4-Lite slave answers
  input wire logic [NUM_OSC-1:0] osc_ready_i, // Raw oscillator ready
  input wire logic switch_enable_cfg_i,     // Nonvolatile switch enable
  output logic [2:0] sys_clk_src_o,         // Selected clock source
  output logic [3:0] sys_clk_div_o,         // Selected post divider
  output logic [NUM_OSC-1:0] osc_force_en_o, // Oscillator force enables
  output logic [3:0] freq_select_o,         // Internal oscillator frequency
  output logic mf_clock_stall_o,            // Hold mid clock static
  output logic clock_switch_irq_o           // Switch interrupt request
);

  // Bus state
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic wstrb0;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // Block state
  clock_sel_s req, cur, tgt;
  switch_state_e state;
  logic switch_hold, new_source_ready, switch_ready;
  logic clock_switch_flag, clock_switch_irq_enable;
  logic [NUM_OSC-1:0] manual_en;
  logic [NUM_OSC-1:0] osc_status;
  logic [NUM_OSC:0] status_ext;
  logic settled;
  logic wr_req, wr_freq, wr_stat, wr_irq;
  logic tgt_ok, nosr_set;

  assign axil_rsp_o = '{awready: awready, wready: wready, bvalid: bvalid,
                        bresp: bresp, arready: arready, rvalid: rvalid,
                        rdata: rdata, rresp: rresp};

  // Write performed once address and data are both held
  assign wr_fire = !awready && !wready && !bvalid;
  assign wr_hit = (waddr == CLOCK_REQUEST_OFS) ||
                  (waddr == CLOCK_CURRENT_OFS) ||
                  (waddr == SWITCH_STATUS_OFS) ||
                  (waddr == OSC_STATUS_OFS) ||
                  (waddr == OSC_ENABLE_OFS) ||
                  (waddr == FREQ_SELECT_OFS) ||
                  (waddr == SWITCH_IRQ_OFS);
  assign wr_req = wr_fire && wstrb0 && (waddr == CLOCK_REQUEST_OFS);
  assign wr_stat = wr_fire && wstrb0 && (waddr == SWITCH_STATUS_OFS);
  assign wr_freq = wr_fire && wstrb0 && (waddr == FREQ_SELECT_OFS);
  assign wr_irq = wr_fire && wstrb0 && (waddr == SWITCH_IRQ_OFS);

  // Write channels: take address and data in either order
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr <= '0;
      wdata <= '0;
      wstrb0 <= 1'b0;
    end else begin
      if (awready && axil_req_i.awvalid) begin
        awready <= 1'b0;
        waddr <= axil_req_i.awaddr;
      end
      if (wready && axil_req_i.wvalid) begin
        wready <= 1'b0;
        wdata <= axil_req_i.wdata;
        wstrb0 <= axil_req_i.wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && axil_req_i.bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read word mux; unused upper bits read zero
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (axil_req_i.araddr == CLOCK_REQUEST_OFS) begin
      rd_word[SRC_LSB +: 3] = req.src;
      rd_word[DIV_LSB +: 4] = req.div;
    end else if (axil_req_i.araddr == CLOCK_CURRENT_OFS) begin
      rd_word[SRC_LSB +: 3] = cur.src;
      rd_word[DIV_LSB +: 4] = cur.div;
    end else if (axil_req_i.araddr == SWITCH_STATUS_OFS) begin
      rd_word[HOLD_BIT] = switch_hold;
      rd_word[READY_BIT] = switch_ready;
      rd_word[NEW_READY_BIT] = new_source_ready;
    end else if (axil_req_i.araddr == OSC_STATUS_OFS) begin
      rd_word[NUM_OSC-1:0] = osc_status;
    end else if (axil_req_i.araddr == OSC_ENABLE_OFS) begin
      rd_word[NUM_OSC-1:0] = manual_en;
    end else if (axil_req_i.araddr == FREQ_SELECT_OFS) begin
      rd_word[3:0] = freq_select_o;
    end else if (axil_req_i.araddr == SWITCH_IRQ_OFS) begin
      rd_word[FLAG_BIT] = clock_switch_flag;
      rd_word[IRQ_EN_BIT] = clock_switch_irq_enable;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arready && axil_req_i.arvalid) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && axil_req_i.rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Request register; locked when switching is disabled by configuration
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      req <= '{src: RST_SRC, div: RST_DIV};
    end else if (wr_req && switch_enable_cfg_i) begin
      req.src <= wdata[SRC_LSB +: 3];
      req.div <= wdata[DIV_LSB +: 4];
    end
  end

  // Software control bits
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      switch_hold <= 1'b0;
      manual_en <= '0;
      freq_select_o <= RST_FREQ;
      clock_switch_irq_enable <= 1'b0;
    end else begin
      if (wr_stat) begin
        switch_hold <= wdata[HOLD_BIT];
      end
      if (wr_fire && wstrb0 && (waddr == OSC_ENABLE_OFS)) begin
        manual_en <= wdata[NUM_OSC-1:0];
      end
      if (wr_freq) begin
        freq_select_o <= wdata[3:0];
      end
      if (wr_irq) begin
        clock_switch_irq_enable <= wdata[IRQ_EN_BIT];
      end
    end
  end

  // PLL bit masked so software can never force it on
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      osc_force_en_o <= '0;
    end else begin
      osc_force_en_o <= manual_en & MANUAL_EN_MASK;
    end
  end

  // Settling of internal oscillators after a frequency change
  osc_settle_timer settle_u (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .restart_i(wr_freq),
    .settled_o(settled)
  );

  // Per oscillator ready; internal ones also wait for settling
  generate
    for (genvar i = 0; i < NUM_OSC; i++) begin : g_stat
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          osc_status[i] <= 1'b0;
        end else if (i == HIGH_FREQ_IDX || i == MID_FREQ_IDX) begin
          osc_status[i] <= osc_ready_i[i] && settled;
        end else begin
          osc_status[i] <= osc_ready_i[i];
        end
      end
    end
  endgenerate

  // Mid clock parked while the high oscillator restarts
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mf_clock_stall_o <= 1'b0;
    end else begin
      mf_clock_stall_o <= !settled;
    end
  end

  // Running source, or divider-only change, is ready at once
  assign status_ext = {1'b0, osc_status};
  assign tgt_ok = (tgt.src == cur.src) || status_ext[tgt.src];
  assign nosr_set = (state == SW_WAIT) && (req == tgt) && tgt_ok;

  // Switch sequencer; old selection keeps running until commit
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state <= SW_IDLE;
      tgt <= '{src: RST_SRC, div: RST_DIV};
      cur <= '{src: RST_SRC, div: RST_DIV};
      new_source_ready <= 1'b0;
      switch_ready <= 1'b1;
    end else begin
      case (state)
        SW_IDLE: begin
          if (req != cur) begin
            tgt <= req;
            switch_ready <= 1'b0;
            state <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (req != tgt) begin
            state <= SW_IDLE;
          end else if (tgt_ok) begin
            new_source_ready <= 1'b1;
            state <= SW_READY;
          end
        end
        SW_READY: begin
          // Request moved (e.g. current copied back): abandon
          if (req != tgt) begin
            new_source_ready <= 1'b0;
            state <= SW_IDLE;
          end else if (!switch_hold) begin
            // Commit does not wait on the CPU being clocked
            cur <= tgt;
            switch_ready <= 1'b1;
            new_source_ready <= 1'b0;
            state <= SW_IDLE;
          end
        end
        default: begin
          state <= SW_IDLE;
        end
      endcase
    end
  end

  // Selection outputs follow the committed choice only
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sys_clk_src_o <= RST_SRC;
      sys_clk_div_o <= RST_DIV;
    end else begin
      sys_clk_src_o <= cur.src;
      sys_clk_div_o <= cur.div;
    end
  end

  // Flag: write one clears, a new ready event wins
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      clock_switch_flag <= 1'b0;
    end else if (nosr_set) begin
      clock_switch_flag <= 1'b1;
    end else if (wr_irq && wdata[FLAG_BIT]) begin
      clock_switch_flag <= 1'b0;
    end
  end

  // Request is not routed to any wake logic
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      clock_switch_irq_o <= 1'b0;
    end else begin
      clock_switch_irq_o <= clock_switch_flag && clock_switch_irq_enable;
    end
  end

  flag_with_ready_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(new_source_ready) |-> clock_switch_flag)
    else $error("flag missing when new source ready set");

  irq_gate_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    (clock_switch_flag && clock_switch_irq_enable) [*2] |-> clock_switch_irq_o)
    else $error("enabled flag gave no interrupt");

  irq_blocked_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    !clock_switch_irq_enable [*2] |-> !clock_switch_irq_o)
    else $error("interrupt raised while disabled");

  hold_keeps_old_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    switch_hold && new_source_ready |=> $stable(cur))
    else $error("changeover during hold");

  commit_clears_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    $changed(cur) |-> !new_source_ready && switch_ready)
    else $error("commit left new ready set or ready clear");

  freq_clear_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    wr_freq |-> ##2 !osc_status[HIGH_FREQ_IDX] && !osc_status[MID_FREQ_IDX])
    else $error("internal ready kept after frequency write");

  stall_pairs_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    mf_clock_stall_o |-> !osc_status[HIGH_FREQ_IDX])
    else $error("mid clock stalled while high oscillator ready");

  req_locked_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    wr_req && !switch_enable_cfg_i |=> $stable(req))
    else $error("request written while switching disabled");

  div_only_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    state == SW_WAIT && req == tgt && tgt.src == cur.src
    |=> new_source_ready)
    else $error("running source not ready at once");

  pll_never_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    !osc_force_en_o[PLL_IDX])
    else $error("PLL forced on");

endmodule
`default_nettype wire

// file: osc_source_model.sv
// Purpose: Oscillator sources seen by the clock switch control.
// Assumes: Internal oscillators 3 and 4 always run.
// Notes: Source 2 starts slowly so a switch has to wait for it.
`timescale 1ns/10ps
`default_nettype none
module osc_source_model
  import clk_switch_pkg::*;
(
  input wire logic clock_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire logic [NUM_OSC-1:0] start_i, // Started by the bench
  input wire logic [NUM_OSC-1:0] force_en_i, // Forced on by the block
  output logic [NUM_OSC-1:0] ready_o // Stable and ready
);
  logic [NUM_OSC-1:0] on;
  logic [5:0] age [NUM_OSC];
  // Internal oscillators never stop
  assign on = start_i | force_en_i | 7'h18;
  // Start-up timers, cleared while an oscillator is off
  always_ff @(posedge clock_i) begin
    for (int n = 0; n < NUM_OSC; n++) begin
      if (!nrst_i || !on[n]) begin
        age[n] <= 6'h00;
      end else if (age[n] != 6'h3F) begin
        age[n] <= age[n] + 6'h01;
      end
    end
  end
  // Ready only after start-up; an off source is never ready
  always_comb begin
    for (int n = 0; n < NUM_OSC; n++) begin
      ready_o[n] = on[n] && (age[n] >= ((n == 2) ? 6'h28 : 6'h03));
    end
  end
endmodule
`default_nettype wire

// file: system_clock_switch_control_test.sv
// Purpose: Self-checking bench for the system clock switch control.
// Assumes: Register map and bus timing as the block itself defines them.
// Notes: Sleep and reduced CPU rate have no ports, so are not driven.
`timescale 1ns/10ps
`default_nettype none
module system_clock_switch_control_test
  import clk_switch_pkg::*;
;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cfg = 1'b1;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic [NUM_OSC-1:0] start = '0;
  logic [NUM_OSC-1:0] osc_ready;
  logic [NUM_OSC-1:0] force_en;
  logic [2:0] src;
  logic [3:0] div;
  logic [3:0] freq;
  logic stall;
  logic irq;
  logic [31:0] rd;
  logic [1:0] resp;
  int miscompares = 0;
  int total_checks = 0;

  // 40 MHz system clock
  always #12.5 clock_i = ~clock_i;

  clk_switch_ctrl DUT (.clock_i(clock_i), .nrst_i(nrst_i),
    .axil_req_i(req), .axil_rsp_o(rsp), .osc_ready_i(osc_ready),
    .switch_enable_cfg_i(cfg), .sys_clk_src_o(src), .sys_clk_div_o(div),
    .osc_force_en_o(force_en), .freq_select_o(freq),
    .mf_clock_stall_o(stall), .clock_switch_irq_o(irq));

  osc_source_model osc (.clock_i(clock_i), .nrst_i(nrst_i),
    .start_i(start), .force_en_i(force_en), .ready_o(osc_ready));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Write; bready stays high for the whole run, so it is never re-driven
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    forever begin
      @(posedge clock_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        break;
      end
    end
  endtask

  // Read; rready likewise stays high
  task automatic axi_rd(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    forever begin
      @(posedge clock_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        resp = rsp.rresp;
        break;
      end
    end
  endtask

  // Read until every bit of the mask is set, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    for (int i = 0; i < 300; i++) begin
      axi_rd(a);
      if ((rd & m) === m) break;
    end
  endtask

  task automatic t_reset();
    chk(32'({src, div, freq, stall, irq}), 32'({RST_SRC, RST_DIV, RST_FREQ,
      2'b00}));
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h04);
  endtask

  // Unmapped place and a write to a read-only register
  task automatic t_bus();
    axi_wr(8'h1C, 32'hFF);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_rd(8'h1C);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_wr(CLOCK_CURRENT_OFS, 32'h07);
    chk(32'(resp), 32'(RESP_OKAY));
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h04);
  endtask

  // Divider-only change commits at once, three edges after the write
  task automatic t_div_only();
    axi_wr(CLOCK_REQUEST_OFS, 32'h34);
    cyc(4);
    chk(32'({src, div}), 32'h43);
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h34);
    axi_rd(SWITCH_STATUS_OFS);
    chk(rd & 32'h18, 32'h10);
    axi_rd(SWITCH_IRQ_OFS);
    chk(rd, 32'h01);
  endtask

  task automatic t_irq();
    chk(32'(irq), 32'h0);
    axi_wr(SWITCH_IRQ_OFS, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h1);
    axi_wr(SWITCH_IRQ_OFS, 32'h3);
    cyc(2);
    chk(32'(irq), 32'h0);
    axi_rd(SWITCH_IRQ_OFS);
    chk(rd, 32'h02);
  endtask

  // Slow source: old clock stays until the source is ready
  task automatic t_slow_src();
    axi_wr(CLOCK_REQUEST_OFS, 32'h32);
    cyc(20);
    chk(32'(src), 32'h4);
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h34);
    axi_rd(SWITCH_STATUS_OFS);
    chk(rd & 32'h18, 32'h0);
    start <= 7'h04;
    poll(SWITCH_STATUS_OFS, 32'h10);
    chk(rd & 32'h18, 32'h10);
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h32);
    chk(32'(src), 32'h2);
    axi_rd(SWITCH_IRQ_OFS);
    chk(rd, 32'h03);
    axi_wr(SWITCH_IRQ_OFS, 32'h1);
  endtask

  // Hold, then complete; hold again, then abandon
  task automatic t_hold();
    axi_wr(SWITCH_STATUS_OFS, 32'h80);
    axi_wr(CLOCK_REQUEST_OFS, 32'h34);
    poll(SWITCH_STATUS_OFS, 32'h08);
    chk(rd, 32'h88);
    cyc(5);
    chk(32'(src), 32'h2);
    axi_wr(SWITCH_STATUS_OFS, 32'h00);
    cyc(4);
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h34);
    axi_wr(SWITCH_STATUS_OFS, 32'h80);
    axi_wr(CLOCK_REQUEST_OFS, 32'h54);
    poll(SWITCH_STATUS_OFS, 32'h08);
    cyc(4);
    chk(32'(div), 32'h3);
    axi_wr(CLOCK_REQUEST_OFS, 32'h34);
    cyc(3);
    axi_rd(SWITCH_STATUS_OFS);
    chk(rd & 32'h08, 32'h0);
    axi_wr(SWITCH_STATUS_OFS, 32'h00);
    cyc(4);
    axi_rd(CLOCK_CURRENT_OFS);
    chk(rd, 32'h34);
  endtask

  // Frequency change: internal ready bits drop, mid clock stalls
  task automatic t_freq();
    axi_wr(FREQ_SELECT_OFS, 32'h5);
    cyc(1);
    chk(32'({stall, freq}), 32'h15);
    axi_rd(OSC_STATUS_OFS);
    chk(rd & 32'h18, 32'h0);
    poll(OSC_STATUS_OFS, 32'h18);
    chk(rd & 32'h18, 32'h18);
    chk(32'(stall), 32'h0);
  endtask

  task automatic t_status();
    cyc(2);
    axi_rd(OSC_STATUS_OFS);
    chk(rd, 32'(osc_ready));
  endtask

  // Request writes ignored while switching is disabled
  task automatic t_cfg();
    cfg <= 1'b0;
    axi_wr(CLOCK_REQUEST_OFS, 32'h07);
    chk(32'(resp), 32'(RESP_OKAY));
    cyc(4);
    axi_rd(CLOCK_REQUEST_OFS);
    chk(rd, 32'h34);
    chk(32'(src), 32'h4);
    cfg <= 1'b1;
    axi_wr(CLOCK_REQUEST_OFS, 32'h44);
    cyc(5);
    chk(32'(div), 32'h4);
  endtask

  task automatic t_force();
    axi_wr(OSC_ENABLE_OFS, 32'h7F);
    // Enable output is launched at the edge the task returns on
    cyc(1);
    chk(32'(force_en), 32'(MANUAL_EN_MASK));
    axi_rd(OSC_ENABLE_OFS);
    chk(rd, 32'h7F);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after four cycles of reset
  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_bus();
    t_div_only();
    t_irq();
    t_slow_src();
    t_hold();
    t_freq();
    t_status();
    t_cfg();
    t_force();
    results();
  end

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
